// ---- verilog/gpm_port.v ----
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/1ps
`include "gpm_consts.vh"
// How it works
// - eight pins, each own direction bit
// - direction 1: input, driver released
// - direction 0: pin drives latch bit
// - latch register reads latch, not pins
// - reset sets every direction bit to input but leaves the bus enabled
// - port usable only with bus disabled
// - bus enabled: pins carry address/data low
// - bus outputs beat all; bus inputs TTL
// - slave enable bit makes parallel port
// - parallel port beats latch only; bus and serial beat it
// - Schmitt normally, TTL in parallel mode
// - parallel read data from latch bits
// - bit 4 serial data out, dir 0
// - bit 5 serial data in, dir 1
// - bit 6 serial clock out or in
// - I2C: clock bit 6, data bit 5
// - bit 7 slave select input, TTL
module gpm_port
#(
    parameter WIDTH = 8,
    parameter HAS_EXT_BUS = 1
)
(
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // axi4-lite write
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    // package pins
    input wire [WIDTH-1:0] pin_i,
    output wire [WIDTH-1:0] pin_o,
    output wire [WIDTH-1:0] pin_oe,
    output wire [WIDTH-1:0] pin_ttl_sel,
    // external memory bus, low address/data byte
    input wire [WIDTH-1:0] ext_ad_out,
    input wire ext_ad_out_en,
    output reg [WIDTH-1:0] ext_ad_in,
    // parallel slave port data
    input wire psp_read_drive,
    output reg [WIDTH-1:0] psp_write_data,
    // second serial unit
    input wire serial_two_data_out,
    input wire serial_two_data_out_en,
    input wire serial_two_spi_clock_out,
    input wire serial_two_i2c_clock_oe,
    input wire serial_two_i2c_data_oe,
    output reg serial_two_data_in,
    output reg serial_two_spi_clock_in,
    output reg serial_two_i2c_clock,
    output reg serial_two_i2c_data,
    output reg serial_two_slave_select
);
    reg [WIDTH-1:0] port_output_latch;
    reg [WIDTH-1:0] port_direction;
    reg [7:0] memory_ctrl_reg;
    reg [7:0] parallel_slave_ctrl_reg;
    reg [7:0] serial_cfg;
    reg [WIDTH-1:0] pin_sample;

    wire wr_stb;
    wire [7:0] wr_addr;
    wire [7:0] wr_data;
    wire rd_stb;
    wire [7:0] rd_addr;
    reg [7:0] rd_data;
    reg rd_err;
    reg wr_err;

    wire ext_bus_disable = memory_ctrl_reg[`GPM_BIT_EXT_BUS_DISABLE];
    wire parallel_slave_enable = parallel_slave_ctrl_reg[`GPM_BIT_PSP_ENABLE];
    wire ser_en = serial_cfg[`GPM_BIT_SER_ENABLE];
    wire ser_i2c = serial_cfg[`GPM_BIT_SER_I2C];
    wire ser_smb = serial_cfg[`GPM_BIT_SER_I2C_SMB];
    wire ser_spi = ser_en & ~ser_i2c;
    wire ser_i2c_on = ser_en & ser_i2c;
    wire bus_active = (HAS_EXT_BUS != 0) & ~ext_bus_disable;
    wire psp_active = parallel_slave_enable & ~bus_active;

    reg [WIDTH-1:0] ser_oe;
    reg [WIDTH-1:0] ser_val;
    wire [WIDTH-1:0] cell_ttl;

    gpm_axil_slave u_bus
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(s_axi_awaddr),
        .awvalid(s_axi_awvalid),
        .awready(s_axi_awready),
        .wdata(s_axi_wdata),
        .wstrb(s_axi_wstrb),
        .wvalid(s_axi_wvalid),
        .wready(s_axi_wready),
        .bresp(s_axi_bresp),
        .bvalid(s_axi_bvalid),
        .bready(s_axi_bready),
        .araddr(s_axi_araddr),
        .arvalid(s_axi_arvalid),
        .arready(s_axi_arready),
        .rdata(s_axi_rdata),
        .rresp(s_axi_rresp),
        .rvalid(s_axi_rvalid),
        .rready(s_axi_rready),
        .wr_stb(wr_stb),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_err(wr_err),
        .rd_addr(rd_addr),
        .rd_stb(rd_stb),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    // serial unit overrides, by pin
    always @*
    begin
        ser_oe = {WIDTH{1'b0}};
        ser_val = {WIDTH{1'b0}};
        if (ser_spi)
        begin
            // data out only while its direction bit is 0
            ser_oe[`GPM_PIN_SDO] = serial_two_data_out_en & ~port_direction[`GPM_PIN_SDO];
            ser_val[`GPM_PIN_SDO] = serial_two_data_out;
            ser_oe[`GPM_PIN_SCK] = ~port_direction[`GPM_PIN_SCK];
            ser_val[`GPM_PIN_SCK] = serial_two_spi_clock_out;
        end
        else if (ser_i2c_on)
        begin
            // open drain: pull low only
            ser_oe[`GPM_PIN_SCK] = serial_two_i2c_clock_oe;
            ser_oe[`GPM_PIN_SDI] = serial_two_i2c_data_oe;
        end
    end

    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1)
        begin : g_pin
            gpm_pin_cell u_cell
            (
                .bus_active(bus_active),
                .psp_active(psp_active),
                .psp_drive(psp_read_drive),
                .ser_out_en(ser_oe[g]),
                .ser_out(ser_val[g]),
                .dir_in(port_direction[g]),
                .latch(port_output_latch[g]),
                .bus_out_en(ext_ad_out_en),
                .bus_out(ext_ad_out[g]),
                .pin_o(pin_o[g]),
                .pin_oe(pin_oe[g]),
                .ttl_sel(cell_ttl[g])
            );
        end
    endgenerate

    // input buffer types beyond the per-pin mux
    reg [WIDTH-1:0] buf_ttl;
    always @*
    begin
        buf_ttl = cell_ttl;
        if (ser_spi)
            buf_ttl[`GPM_PIN_SS] = 1'b1;
    end

    // slave select pin reaches its buffer as TTL in spi mode
    assign pin_ttl_sel = buf_ttl;

    // register writes
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            port_output_latch <= `GPM_RST_LATCH;
            port_direction <= `GPM_RST_DIRECTION;
            memory_ctrl_reg <= `GPM_RST_MEM_CTRL;
            parallel_slave_ctrl_reg <= `GPM_RST_PSP_CTRL;
            serial_cfg <= `GPM_RST_SERIAL_CFG;
        end
        else if (wr_stb && !wr_err)
        begin
            case (wr_addr)
                `GPM_OFF_PIN_VALUE: port_output_latch <= wr_data[WIDTH-1:0];
                `GPM_OFF_LATCH: port_output_latch <= wr_data[WIDTH-1:0];
                `GPM_OFF_DIRECTION: port_direction <= wr_data[WIDTH-1:0];
                `GPM_OFF_MEM_CTRL: memory_ctrl_reg <= wr_data;
                `GPM_OFF_PSP_CTRL: parallel_slave_ctrl_reg <= wr_data;
                `GPM_OFF_SERIAL_CFG: serial_cfg <= wr_data;
                default: serial_cfg <= serial_cfg;
            endcase
        end
    end

    always @*
    begin
        case (wr_addr)
            `GPM_OFF_PIN_VALUE, `GPM_OFF_LATCH, `GPM_OFF_DIRECTION,
            `GPM_OFF_MEM_CTRL, `GPM_OFF_PSP_CTRL, `GPM_OFF_SERIAL_CFG: wr_err = 1'b0;
            default: wr_err = 1'b1;
        endcase
    end

    // register reads
    always @*
    begin
        rd_err = 1'b0;
        rd_data = 8'h00;
        case (rd_addr)
            `GPM_OFF_PIN_VALUE: rd_data = pin_sample;
            `GPM_OFF_LATCH: rd_data = port_output_latch;
            `GPM_OFF_DIRECTION: rd_data = port_direction;
            `GPM_OFF_MEM_CTRL: rd_data = memory_ctrl_reg;
            `GPM_OFF_PSP_CTRL: rd_data = parallel_slave_ctrl_reg;
            `GPM_OFF_SERIAL_CFG: rd_data = serial_cfg;
            `GPM_OFF_BUFTYPE: rd_data = buf_ttl;
            default: rd_err = 1'b1;
        endcase
    end

    // pin sampling and peripheral inputs
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_sample <= {WIDTH{1'b0}};
            ext_ad_in <= {WIDTH{1'b0}};
            psp_write_data <= {WIDTH{1'b0}};
            serial_two_data_in <= 1'b0;
            serial_two_spi_clock_in <= 1'b0;
            serial_two_i2c_clock <= 1'b1;
            serial_two_i2c_data <= 1'b1;
            serial_two_slave_select <= 1'b1;
        end
        else
        begin
            pin_sample <= pin_i;
            ext_ad_in <= bus_active ? pin_i : {WIDTH{1'b0}};
            psp_write_data <= psp_active ? pin_i : {WIDTH{1'b0}};
            serial_two_data_in <= (ser_spi & port_direction[`GPM_PIN_SDI])
                ? pin_i[`GPM_PIN_SDI] : 1'b0;
            serial_two_spi_clock_in <= (ser_spi & port_direction[`GPM_PIN_SCK])
                ? pin_i[`GPM_PIN_SCK] : 1'b0;
            serial_two_i2c_clock <= ser_i2c_on ? pin_i[`GPM_PIN_SCK] : 1'b1;
            serial_two_i2c_data <= ser_i2c_on ? pin_i[`GPM_PIN_SDI] : 1'b1;
            serial_two_slave_select <= (ser_spi & port_direction[`GPM_PIN_SS])
                ? pin_i[`GPM_PIN_SS] : 1'b1;
        end
    end
    // i2c/smb buffer level bit 2 of serial_cfg is stored but selects no buffer
    wire unused_smb = ser_smb;
endmodule

// ---- pkg/gpm_consts.vh ----
`ifndef GPM_CONSTS_VH
`define GPM_CONSTS_VH

// register byte offsets
`define GPM_OFF_PIN_VALUE 8'h00
`define GPM_OFF_LATCH 8'h04
`define GPM_OFF_DIRECTION 8'h08
`define GPM_OFF_MEM_CTRL 8'h0c
`define GPM_OFF_PSP_CTRL 8'h10
`define GPM_OFF_SERIAL_CFG 8'h14
`define GPM_OFF_BUFTYPE 8'h18

// field positions
`define GPM_BIT_EXT_BUS_DISABLE 7
`define GPM_BIT_PSP_ENABLE 4
`define GPM_BIT_SER_ENABLE 0
`define GPM_BIT_SER_I2C 1
`define GPM_BIT_SER_I2C_SMB 2
`define GPM_PIN_SDO 4
`define GPM_PIN_SDI 5
`define GPM_PIN_SCK 6
`define GPM_PIN_SS 7

// reset values
`define GPM_RST_DIRECTION 8'hff
`define GPM_RST_LATCH 8'h00
`define GPM_RST_MEM_CTRL 8'h00
`define GPM_RST_PSP_CTRL 8'h00
`define GPM_RST_SERIAL_CFG 8'h00

// AXI responses
`define GPM_RESP_OKAY 2'b00
`define GPM_RESP_SLVERR 2'b10

`endif

// ---- verilog/gpm_pin_cell.v ----
`timescale 1ns/1ps
// one pin: output mux in priority order and input buffer select
module gpm_pin_cell
(
    // controls
    input wire bus_active,
    input wire psp_active,
    input wire psp_drive,
    input wire ser_out_en,
    input wire ser_out,
    input wire dir_in,
    input wire latch,
    input wire bus_out_en,
    input wire bus_out,
    // pin
    output reg pin_o,
    output reg pin_oe,
    // input buffer type: 1 = TTL
    output wire ttl_sel
);
    always @*
    begin
        if (bus_active)
        begin
            pin_oe = bus_out_en;
            pin_o = bus_out;
        end
        else if (ser_out_en)
        begin
            pin_oe = 1'b1;
            pin_o = ser_out;
        end
        else if (psp_active)
        begin
            pin_oe = psp_drive;
            pin_o = latch;
        end
        else
        begin
            pin_oe = ~dir_in;
            pin_o = latch;
        end
    end

    assign ttl_sel = bus_active | psp_active;
endmodule

// ---- verilog/gpm_axil_slave.v ----
`timescale 1ns/1ps
`include "gpm_consts.vh"
// axi4-lite slave: one write and one read at a time
module gpm_axil_slave
(
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // write channels
    input wire [7:0] awaddr,
    input wire awvalid,
    output wire awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output wire wready,
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    // read channels
    input wire [7:0] araddr,
    input wire arvalid,
    output wire arready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    // register side
    output wire wr_stb,
    output wire [7:0] wr_addr,
    output wire [7:0] wr_data,
    input wire wr_err,
    output wire [7:0] rd_addr,
    output wire rd_stb,
    input wire [7:0] rd_data,
    input wire rd_err
);
    reg aw_held;
    reg w_held;
    reg [7:0] aw_q;
    reg [7:0] w_q;
    reg wbe_q;

    assign awready = ~aw_held & ~bvalid;
    assign wready = ~w_held & ~bvalid;
    assign arready = ~rvalid;
    assign wr_stb = aw_held & w_held & ~bvalid;
    assign wr_addr = aw_q;
    assign wr_data = w_q;
    assign rd_addr = araddr;
    assign rd_stb = arvalid & ~rvalid;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_q <= 8'h00;
            w_q <= 8'h00;
            wbe_q <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `GPM_RESP_OKAY;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `GPM_RESP_OKAY;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_held <= 1'b1;
                aw_q <= awaddr;
            end
            if (wvalid && wready)
            begin
                w_held <= 1'b1;
                w_q <= wdata[7:0];
                wbe_q <= wstrb[0];
            end
            if (wr_stb)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_err ? `GPM_RESP_SLVERR : `GPM_RESP_OKAY;
            end
            else if (bvalid && bready)
                bvalid <= 1'b0;
            if (rd_stb)
            begin
                rvalid <= 1'b1;
                rdata <= {24'h000000, rd_data};
                rresp <= rd_err ? `GPM_RESP_SLVERR : `GPM_RESP_OKAY;
            end
            else if (rvalid && rready)
                rvalid <= 1'b0;
        end
    end
endmodule

// ---- dv/gpm_port_properties.sv ----
`timescale 1ns/1ps
module gpm_port_props
#(
    parameter WIDTH = 8,
    parameter HAS_EXT_BUS = 1
)
(
    // clock, reset, register writes
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    // pins and peripherals
    input wire [WIDTH-1:0] pin_i,
    input wire [WIDTH-1:0] pin_o,
    input wire [WIDTH-1:0] pin_oe,
    input wire [WIDTH-1:0] pin_ttl_sel,
    input wire [WIDTH-1:0] ext_ad_out,
    input wire ext_ad_out_en,
    input wire [WIDTH-1:0] ext_ad_in,
    input wire psp_read_drive,
    input wire serial_two_data_out,
    input wire serial_two_data_out_en,
    input wire serial_two_spi_clock_out,
    input wire serial_two_data_in,
    input wire serial_two_slave_select
);
    reg [7:0] sh [0:5];
    reg [7:0] wa;
    reg [7:0] wd;
    reg pend;
    wire [7:0] lat = sh[1];
    wire [7:0] dir = sh[2];
    wire bus = HAS_EXT_BUS != 0 && !sh[3][7];
    wire parallel_slave_port = sh[4][4];
    wire ser = sh[5][0] && !bus;
    wire spi = ser && !sh[5][1];
    // register shadow, committed on the edge the slave commits
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sh[1] <= 8'h00;
            sh[2] <= 8'hff;
            sh[3] <= 8'h00;
            sh[4] <= 8'h00;
            sh[5] <= 8'h00;
            pend <= 1'h0;
        end
        else if (pend)
        begin
            pend <= 1'h0;
            if (wa < 8'h18 && wa[1:0] == 2'h0)
            begin
                sh[(wa[4:2] == 3'h0) ? 3'h1 : wa[4:2]] <= wd;
            end
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            pend <= 1'h1;
            wa <= s_axi_awaddr;
            wd <= s_axi_wdata[7:0];
        end
    end
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_ss_pick;
        spi && dir[7];
    endsequence
    sequence s_ss_seen;
        pin_ttl_sel[7] ##1 serial_two_slave_select == $past(pin_i[7]);
    endsequence
    property p_bus_drive;
        bus && ext_ad_out_en |-> pin_oe == 8'hff && pin_o == ext_ad_out;
    endproperty
    a_bus_drive: assert property (p_bus_drive) else $error("bus data not on pins");
    property p_bus_in;
        bus |=> ext_ad_in == $past(pin_i);
    endproperty
    a_bus_in: assert property (p_bus_in) else $error("bus input not sampled");
    property p_port;
        !bus && !parallel_slave_port && !sh[5][0] |-> pin_oe == ~dir && (pin_o & ~dir) == (lat & ~dir);
    endproperty
    a_port: assert property (p_port) else $error("port pin drive wrong");
    property p_psp_read;
        !bus && parallel_slave_port && !sh[5][0] && psp_read_drive |-> pin_oe == 8'hff && pin_o == lat;
    endproperty
    a_psp_read: assert property (p_psp_read) else $error("parallel read data wrong");
    property p_ttl;
        bus || !sh[5][0] |-> pin_ttl_sel == {8{bus || parallel_slave_port}};
    endproperty
    a_ttl: assert property (p_ttl) else $error("input buffer type wrong");
    property p_sdo;
        spi && serial_two_data_out_en && !dir[4] && !dir[6]
            |-> pin_oe[4] && pin_oe[6] && pin_o[4] == serial_two_data_out
            && pin_o[6] == serial_two_spi_clock_out;
    endproperty
    a_sdo: assert property (p_sdo) else $error("serial outputs not on pins");
    property p_sdi;
        spi && dir[5] |=> serial_two_data_in == $past(pin_i[5]);
    endproperty
    a_sdi: assert property (p_sdi) else $error("serial data in wrong");
    property p_ss;
        s_ss_pick |-> s_ss_seen;
    endproperty
    a_ss: assert property (p_ss) else $error("slave select wrong");
endmodule
bind gpm_port gpm_port_props #(.WIDTH(WIDTH), .HAS_EXT_BUS(HAS_EXT_BUS)) gpm_port_props_i (.*);

// ---- dv/gpm_pin_model.sv ----
`timescale 1ns/1ps
module gpm_pin_model
(
    // clock
    input wire aclk,
    // device pins
    input wire [7:0] pin_o,
    input wire [7:0] pin_oe,
    output wire [7:0] pin_i,
    // board drivers
    input wire [7:0] ext_en,
    input wire [7:0] ext_lvl
);
    reg [7:0] wander = 8'h55;
    // two-wire lines pulled up, other released lines keep changing
    wire [7:0] idle = wander | 8'h60;
    always @(posedge aclk)
    begin
        wander <= ~wander;
    end
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_lvl) | (~pin_oe & ~ext_en & idle);
endmodule

// ---- dv/gpm_port_tb.sv ----
`timescale 1ns/1ps
`include "gpm_consts.vh"
module gpm_port_tb;
    localparam [1:0] OK = `GPM_RESP_OKAY;
    localparam [1:0] BAD = `GPM_RESP_SLVERR;
    reg aclk = 1'h0;
    reg aresetn = 1'h0;
    reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    reg [31:0] s_axi_wdata = 32'h0;
    reg [3:0] s_axi_wstrb = 4'hf;
    reg s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    reg s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, ext_ad_out_en = 1'h0, psp_read_drive = 1'h0;
    reg [7:0] ext_ad_out = 8'h00, ext_en = 8'h00, ext_lvl = 8'h00;
    reg serial_two_data_out = 1'h0, serial_two_data_out_en = 1'h0, serial_two_spi_clock_out = 1'h0;
    reg serial_two_i2c_clock_oe = 1'h0, serial_two_i2c_data_oe = 1'h0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [7:0] pin_i, pin_o, pin_oe, pin_ttl_sel, ext_ad_in, psp_write_data;
    wire serial_two_data_in, serial_two_spi_clock_in, serial_two_i2c_clock, serial_two_i2c_data;
    wire serial_two_slave_select;
    integer num_errors = 0, cmp_count = 0, cyc = 0, i;
    reg [31:0] seed = 32'h44;
    reg [33:0] rq[$];
    reg [1:0] bq[$];
    reg ok_a, ok_w, done;
    reg [7:0] v, d, l;
    gpm_port #(.WIDTH(8), .HAS_EXT_BUS(1)) gpm_port_i (.*);
    gpm_pin_model gpm_pin_model_i (.aclk(aclk), .pin_o(pin_o), .pin_oe(pin_oe), .pin_i(pin_i),
        .ext_en(ext_en), .ext_lvl(ext_lvl));
    always #50 aclk = ~aclk;
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    task chk(input string n, input [33:0] e, input [33:0] s);
        cmp_count = cmp_count + 1;
        if (s !== e)
        begin
            num_errors = num_errors + 1;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask
    task test_done;
        $display("checks %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task wr(input [7:0] a, input [7:0] dv, input [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, dv};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        bq.push_back(r);
        done = 1'h0;
        while (!done)
        begin
            @(negedge aclk);
            ok_a = s_axi_awready;
            ok_w = s_axi_wready;
            done = s_axi_bvalid;
            @(posedge aclk);
            if (ok_a)
                s_axi_awvalid <= 1'h0;
            if (ok_w)
                s_axi_wvalid <= 1'h0;
        end
        s_axi_bready <= 1'h0;
    endtask
    task rd(input [7:0] a, input [1:0] r, input [7:0] e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        rq.push_back({r, 24'h0, e});
        done = 1'h0;
        while (!done)
        begin
            @(negedge aclk);
            ok_a = s_axi_arready;
            done = s_axi_rvalid;
            @(posedge aclk);
            if (ok_a)
                s_axi_arvalid <= 1'h0;
        end
        s_axi_rready <= 1'h0;
    endtask
    // response watcher against the queued notes
    always @(posedge aclk)
    begin
        cyc = cyc + 1;
        if (s_axi_rvalid && s_axi_rready)
            chk("rdata", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
        if (s_axi_bvalid && s_axi_bready)
            chk("bresp", 34'(bq.pop_front()), 34'(s_axi_bresp));
        if (cyc == 3000)
        begin
            num_errors = num_errors + 1;
            test_done;
        end
    end
    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        @(negedge aclk);
        chk("oe", 34'(8'h00), 34'(pin_oe));
        rd(`GPM_OFF_DIRECTION, OK, 8'hff);
        rd(`GPM_OFF_LATCH, OK, 8'h00);
        v = rnd();
        ext_ad_out <= v;
        ext_ad_out_en <= 1'h1;
        wr(`GPM_OFF_DIRECTION, 8'h00, OK);
        @(negedge aclk);
        chk("bus", {18'h0, 8'hff, v}, {18'h0, pin_oe, pin_o});
        l = rnd();
        @(posedge aclk);
        ext_ad_out_en <= 1'h0;
        ext_en <= 8'hff;
        ext_lvl <= l;
        @(posedge aclk);
        @(negedge aclk);
        chk("bus_in", {18'h0, 8'h00, l}, {18'h0, pin_oe, ext_ad_in});
        wr(`GPM_OFF_MEM_CTRL, 8'h80, OK);
        for (i = 0; i < 4; i = i + 1)
        begin
            v = rnd();
            d = rnd();
            l = rnd();
            wr(i[0] ? `GPM_OFF_PIN_VALUE : `GPM_OFF_LATCH, v, OK);
            wr(`GPM_OFF_DIRECTION, d, OK);
            ext_en <= d;
            ext_lvl <= l;
            rd(`GPM_OFF_LATCH, OK, v);
            @(negedge aclk);
            chk("port", {18'h0, ~d, v & ~d}, {18'h0, pin_oe, pin_o & ~d});
            rd(`GPM_OFF_PIN_VALUE, OK, (v & ~d) | (l & d));
        end
        wr(8'h3c, 8'h5a, BAD);
        rd(8'h3c, BAD, 8'h00);
        wr(`GPM_OFF_DIRECTION, 8'hff, OK);
        wr(`GPM_OFF_PSP_CTRL, 8'h10, OK);
        psp_read_drive <= 1'h1;
        @(negedge aclk);
        chk("psp_rd", {10'h0, 8'hff, v, pin_ttl_sel}, {10'h0, pin_oe, pin_o, 8'hff});
        l = rnd();
        @(posedge aclk);
        psp_read_drive <= 1'h0;
        ext_en <= 8'hff;
        ext_lvl <= l;
        @(posedge aclk);
        @(negedge aclk);
        chk("psp_wr", 34'(l), 34'(psp_write_data));
        wr(`GPM_OFF_SERIAL_CFG, 8'h01, OK);
        wr(`GPM_OFF_DIRECTION, 8'ha0, OK);
        serial_two_data_out_en <= 1'h1;
        serial_two_data_out <= ~v[4];
        serial_two_spi_clock_out <= 1'h1;
        psp_read_drive <= 1'h1;
        @(posedge aclk);
        @(negedge aclk);
        chk("sdo", {32'h0, ~v[4], 1'h1}, {32'h0, pin_o[4], pin_oe[4]});
        chk("sck", 34'h3, {32'h0, pin_o[6], pin_oe[6]});
        chk("sdi", 34'(v[5]), 34'(serial_two_data_in));
        chk("ss", {32'h0, v[7], 1'h1}, {32'h0, serial_two_slave_select, pin_ttl_sel[7]});
        wr(`GPM_OFF_PSP_CTRL, 8'h00, OK);
        wr(`GPM_OFF_DIRECTION, 8'hff, OK);
        wr(`GPM_OFF_SERIAL_CFG, 8'h03, OK);
        psp_read_drive <= 1'h0;
        serial_two_data_out_en <= 1'h0;
        serial_two_i2c_clock_oe <= 1'h1;
        ext_en <= 8'h00;
        @(posedge aclk);
        @(negedge aclk);
        chk("i2c", 34'h11, {29'h0, pin_oe[6:5], pin_o[6], serial_two_i2c_clock,
            serial_two_i2c_data});
        serial_two_i2c_clock_oe <= 1'h0;
        wr(`GPM_OFF_SERIAL_CFG, 8'h01, OK);
        rd(`GPM_OFF_BUFTYPE, OK, 8'h80);
        @(negedge aclk);
        chk("ss_ttl", 34'h1, 34'(pin_ttl_sel[7]));
        test_done;
    end
endmodule
